// *** design/ssp_port.sv ***
`timescale 1ns/1ps
module ssp_port (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic shift_clk_i,
	input wire logic frame_enable_n_i,
	input wire logic serial_data_i,
	input wire logic ref_in_i,
	input wire logic vco_in_i,
	output logic mux_out_o,
	output logic [ssp_pkg::CONFIG_W-1:0] config_o,
	output logic [ssp_pkg::REF_MODE_W-1:0] ref_mode_bits_o,
	output logic [ssp_pkg::REF_DIV_W-1:0] ref_divide_field_o,
	output logic [ssp_pkg::MAIN_W-1:0] main_count_o,
	output logic [ssp_pkg::SWALLOW_W-1:0] swallow_count_o,
	output logic divided_reference_pulse_o,
	output logic divided_vco_pulse_o
);
	// Link domain state
	logic [ssp_pkg::SHIFT_W-1:0] shift;
	logic [ssp_pkg::SHIFT_W-1:0] next_shift;
	logic [ssp_pkg::CNT_W-1:0] count;
	logic [ssp_pkg::CNT_W-1:0] next_count;
	logic half_stage;
	logic link_rst_n;

	// Core domain state
	logic [ssp_pkg::CONFIG_W-1:0] config_reg;
	logic [ssp_pkg::CONFIG_W-1:0] next_config_reg;
	logic [ssp_pkg::REF_DIV_W-1:0] ref_buf1;
	logic [ssp_pkg::REF_DIV_W-1:0] next_ref_buf1;
	logic [ssp_pkg::REF_DIV_W-1:0] ref_buf2;
	logic [ssp_pkg::REF_DIV_W-1:0] next_ref_buf2;
	logic [ssp_pkg::REF_MODE_W-1:0] ref_mode;
	logic [ssp_pkg::REF_MODE_W-1:0] next_ref_mode;
	logic [ssp_pkg::SHIFT_W-1:0] counter_select_reg;
	logic [ssp_pkg::SHIFT_W-1:0] next_counter_select_reg;
	logic count_clr;
	logic next_count_clr;
	logic [2:0] sync_q;
	logic [2:0] sync_prev;
	logic frame_end;
	logic ref_tick;
	logic vco_tick;
	logic [1:0] out_sel;
	logic [ssp_pkg::VCO_DIV_W-1:0] vco_ratio;

	// Count is cleared by the core after each frame; clock idles then
	assign link_rst_n = rst_n_i & ~count_clr;

	always_comb begin
		next_shift = shift;
		next_count = count;
		if (!frame_enable_n_i) begin
			next_shift = {shift[ssp_pkg::SHIFT_W-2:0], serial_data_i};
			if (count != ssp_pkg::CNT_SAT) begin
				next_count = count + ssp_pkg::CNT_ONE;
			end
		end
	end

	always_ff @(posedge shift_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			shift <= '0;
		end else begin
			shift <= next_shift;
		end
	end

	// Any frame end clears count, recovering after a bad edge
	always_ff @(posedge shift_clk_i or negedge link_rst_n) begin
		if (!link_rst_n) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end

	always_ff @(negedge shift_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			half_stage <= 1'b0;
		end else begin
			half_stage <= shift[ssp_pkg::SHIFT_W-1];
		end
	end

	// Enable enters inverted so the reset level matches the idle pin,
	// otherwise a false frame end follows every reset
	ssp_sync #(
		.W(3)
	) u_sync (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.async_i({vco_in_i, ref_in_i, ~frame_enable_n_i}),
		.sync_o(sync_q)
	);

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sync_prev <= 3'h0;
		end else begin
			sync_prev <= sync_q;
		end
	end

	// Enable rising edge ends the frame
	assign frame_end = ~sync_q[0] & sync_prev[0];
	assign ref_tick = sync_q[1] & ~sync_prev[1];
	assign vco_tick = sync_q[2] & ~sync_prev[2];

	// Shift data and count are quiet once enable is high, so they are
	// read here as stable words qualified by the synchronised enable.
	always_comb begin
		next_config_reg = config_reg;
		next_ref_buf1 = ref_buf1;
		next_ref_buf2 = ref_buf2;
		next_ref_mode = ref_mode;
		next_counter_select_reg = counter_select_reg;
		next_count_clr = frame_end;
		if (frame_end) begin
			case (count)
				ssp_pkg::CNT_CONFIG: begin
					next_config_reg = shift[ssp_pkg::CONFIG_W-1:0];
				end
				ssp_pkg::CNT_REF: begin
					next_ref_buf1 = shift[ssp_pkg::REF_DIV_LSB +: ssp_pkg::REF_DIV_W];
					next_ref_mode = shift[ssp_pkg::REF_MODE_LSB +: ssp_pkg::REF_MODE_W];
				end
				ssp_pkg::CNT_COUNTER: begin
					next_counter_select_reg = shift;
					next_ref_buf2 = ref_buf1;
				end
				ssp_pkg::CNT_EMPTY: begin
					next_ref_buf2 = ref_buf1;
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			config_reg <= ssp_pkg::CONFIG_RST;
			ref_buf1 <= ssp_pkg::REF_DIV_RST;
			ref_buf2 <= ssp_pkg::REF_DIV_RST;
			ref_mode <= ssp_pkg::REF_MODE_RST;
			counter_select_reg <= ssp_pkg::COUNTER_RST;
			count_clr <= 1'b0;
		end else begin
			config_reg <= next_config_reg;
			ref_buf1 <= next_ref_buf1;
			ref_buf2 <= next_ref_buf2;
			ref_mode <= next_ref_mode;
			counter_select_reg <= next_counter_select_reg;
			count_clr <= next_count_clr;
		end
	end

	ssp_div #(
		.W(ssp_pkg::REF_DIV_W)
	) u_ref_div (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.tick_i(ref_tick),
		.ratio_i(ref_buf2),
		.pulse_o(divided_reference_pulse_o)
	);

	// Total ratio main times 64 plus swallow
	assign vco_ratio = {main_count_o, {ssp_pkg::SWALLOW_W{1'b0}}}
		+ {{ssp_pkg::MAIN_W{1'b0}}, swallow_count_o};

	ssp_div #(
		.W(ssp_pkg::VCO_DIV_W)
	) u_vco_div (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.tick_i(vco_tick),
		.ratio_i(vco_ratio),
		.pulse_o(divided_vco_pulse_o)
	);

	assign out_sel = {counter_select_reg[ssp_pkg::OUT_SELECT_HI_POS],
		counter_select_reg[ssp_pkg::OUT_SELECT_LO_POS]};

	always_comb begin
		unique case (out_sel)
			ssp_pkg::SEL_REF: mux_out_o = divided_reference_pulse_o;
			ssp_pkg::SEL_VCO: mux_out_o = divided_vco_pulse_o;
			ssp_pkg::SEL_SERIAL: mux_out_o = half_stage;
			ssp_pkg::SEL_PORT: mux_out_o = config_reg[ssp_pkg::PORT_LEVEL_BIT_POS];
		endcase
	end

	assign config_o = config_reg;
	assign ref_mode_bits_o = ref_mode;
	assign ref_divide_field_o = ref_buf2;
	assign main_count_o = counter_select_reg[ssp_pkg::MAIN_LSB +: ssp_pkg::MAIN_W];
	assign swallow_count_o = counter_select_reg[ssp_pkg::SWALLOW_LSB +: ssp_pkg::SWALLOW_W];

	sequence s_end_cnt(logic [ssp_pkg::CNT_W-1:0] n);
		frame_end && count == n;
	endsequence

	property p_config_load;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		s_end_cnt(ssp_pkg::CNT_CONFIG) |=> config_reg == $past(shift[7:0]);
	endproperty
	a_config_load: assert property (p_config_load) else $error("config not loaded");

	property p_ref_load;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		s_end_cnt(ssp_pkg::CNT_REF) |=> ref_buf1 == $past(shift[12:0])
			&& ref_mode_bits_o == $past(shift[15:13]) && $stable(ref_buf2);
	endproperty
	a_ref_load: assert property (p_ref_load) else $error("reference buffer wrong");

	property p_counter_load;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		s_end_cnt(ssp_pkg::CNT_COUNTER) |=> counter_select_reg == $past(shift)
			&& ref_buf2 == $past(ref_buf1);
	endproperty
	a_counter_load: assert property (p_counter_load) else $error("counter load wrong");

	property p_empty_frame;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		s_end_cnt(ssp_pkg::CNT_EMPTY) |=> ref_buf2 == $past(ref_buf1)
			&& $stable(counter_select_reg);
	endproperty
	a_empty_frame: assert property (p_empty_frame) else $error("empty frame no copy");

	property p_hold;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		!frame_end |=> $stable(config_reg) && $stable(counter_select_reg) && $stable(ref_buf1);
	endproperty
	a_hold: assert property (p_hold) else $error("register changed mid frame");

	property p_clear;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		frame_end |=> count_clr ##1 !count_clr;
	endproperty
	a_clear: assert property (p_clear) else $error("count clear pulse wrong");

	property p_idle;
		@(posedge shift_clk_i) disable iff (!rst_n_i)
		frame_enable_n_i |=> $stable(shift);
	endproperty
	a_idle: assert property (p_idle) else $error("shift moved while idle");

	property p_port;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		out_sel == ssp_pkg::SEL_PORT |-> mux_out_o == config_reg[1];
	endproperty
	a_port: assert property (p_port) else $error("port level wrong");

	property p_ref_sel;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		out_sel == ssp_pkg::SEL_REF |-> mux_out_o == divided_reference_pulse_o;
	endproperty
	a_ref_sel: assert property (p_ref_sel) else $error("select wrong");

	property p_default;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		$rose(rst_n_i) |-> out_sel == ssp_pkg::SEL_SERIAL;
	endproperty
	a_default: assert property (p_default) else $error("not serial after reset");
endmodule // ssp_port

// *** shared/ssp_pkg.sv ***
package ssp_pkg;
	// Frame lengths, in shift clock edges
	localparam int CNT_W = 5;
	localparam logic [CNT_W-1:0] CNT_EMPTY = 5'h00;
	localparam logic [CNT_W-1:0] CNT_CONFIG = 5'h08;
	localparam logic [CNT_W-1:0] CNT_REF = 5'h10;
	localparam logic [CNT_W-1:0] CNT_COUNTER = 5'h18;
	localparam logic [CNT_W-1:0] CNT_SAT = 5'h1f;
	localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;

	// Register widths
	localparam int SHIFT_W = 24;
	localparam int CONFIG_W = 8;
	localparam int REF_W = 16;
	localparam int REF_DIV_W = 13;
	localparam int REF_MODE_W = 3;
	localparam int SWALLOW_W = 6;
	localparam int MAIN_W = 12;
	localparam int VCO_DIV_W = MAIN_W + SWALLOW_W;

	// Field positions
	localparam int REF_DIV_LSB = 0;
	localparam int REF_MODE_LSB = 13;
	localparam int SWALLOW_LSB = 0;
	localparam int MAIN_LSB = 6;
	localparam int OUT_SELECT_HI_POS = 23;
	localparam int OUT_SELECT_LO_POS = 22;
	localparam int PORT_LEVEL_BIT_POS = 1;

	// Output select codes {out_select_hi, out_select_lo}
	localparam logic [1:0] SEL_REF = 2'h3;
	localparam logic [1:0] SEL_VCO = 2'h2;
	localparam logic [1:0] SEL_SERIAL = 2'h1;
	localparam logic [1:0] SEL_PORT = 2'h0;

	// Reset values
	localparam logic [CONFIG_W-1:0] CONFIG_RST = 8'h00;
	localparam logic [REF_DIV_W-1:0] REF_DIV_RST = 13'h0000;
	localparam logic [REF_MODE_W-1:0] REF_MODE_RST = 3'h0;
	localparam logic [SHIFT_W-1:0] COUNTER_RST = 24'h400000;
endpackage

// *** design/ssp_sync.sv ***
`timescale 1ns/1ps
module ssp_sync #(
	parameter int W = 1
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);
	logic [W-1:0] stage1;

	// First stage is read only by the second
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			stage1 <= '0;
			sync_o <= '0;
		end else begin
			stage1 <= async_i;
			sync_o <= stage1;
		end
	end
endmodule // ssp_sync

// *** design/ssp_div.sv ***
`timescale 1ns/1ps
module ssp_div #(
	parameter int W = 13
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic tick_i,
	input wire logic [W-1:0] ratio_i,
	output logic pulse_o
);
	logic [W-1:0] count;
	logic [W-1:0] next_count;
	logic next_pulse;

	// Ratio of zero stops the counter; ratio of one passes every tick
	always_comb begin
		next_count = count;
		next_pulse = 1'b0;
		if (tick_i && ratio_i != '0) begin
			if (count == '0 || count >= ratio_i) begin
				next_count = ratio_i - W'(1);
				next_pulse = 1'b1;
			end else begin
				next_count = count - W'(1);
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			count <= '0;
			pulse_o <= 1'b0;
		end else begin
			count <= next_count;
			pulse_o <= next_pulse;
		end
	end
endmodule // ssp_div

// *** tb/ssp_host.sv ***
`timescale 1ns/1ps
module ssp_host (
	input wire logic mux_out_i,
	output logic shift_clk_o,
	output logic frame_enable_n_o,
	output logic serial_data_o
);
	logic seen [1:32];
	initial begin
		shift_clk_o = 1'b0;
		frame_enable_n_o = 1'b1;
		serial_data_o = 1'b0;
	end
	// MSB first, enable moves with clock low
	// Zero bits give the empty frame
	task automatic send(input logic [31:0] w, input int n);
		frame_enable_n_o = 1'b0;
		#40;
		for (int i = n - 1; i >= 0; i--) begin
			serial_data_o = w[i];
			#10 shift_clk_o = 1'b1;
			#15 shift_clk_o = 1'b0;
			#5 seen[n - i] = mux_out_i;
		end
		#15 frame_enable_n_o = 1'b1;
		// Released data line must not look held
		serial_data_o = ~serial_data_o;
		#150;
	endtask
	task automatic stray(input int n);
		repeat (n) begin
			#15 shift_clk_o = 1'b1;
			#15 shift_clk_o = 1'b0;
		end
		#60;
	endtask
endmodule // ssp_host

// *** tb/tb.sv ***
`timescale 1ns/1ps
module tb;
	logic core_clk_i;
	logic rst_n_i;
	logic ref_in_i;
	logic vco_in_i;
	logic sck;
	logic fen_n;
	logic sdat;
	logic mux_out;
	logic [7:0] cfg;
	logic [2:0] mode;
	logic [12:0] rdiv;
	logic [11:0] main_c;
	logic [5:0] swal;
	logic rpulse;
	logic vpulse;
	int err_count;
	int checks_done;
	ssp_port ssp_port_i (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .shift_clk_i(sck),
		.frame_enable_n_i(fen_n), .serial_data_i(sdat), .ref_in_i(ref_in_i),
		.vco_in_i(vco_in_i), .mux_out_o(mux_out), .config_o(cfg), .ref_mode_bits_o(mode),
		.ref_divide_field_o(rdiv), .main_count_o(main_c), .swallow_count_o(swal),
		.divided_reference_pulse_o(rpulse), .divided_vco_pulse_o(vpulse));
	ssp_host ssp_host_i (.mux_out_i(mux_out), .shift_clk_o(sck), .frame_enable_n_o(fen_n),
		.serial_data_o(sdat));
	initial begin
		core_clk_i = 1'b0;
		forever #5 core_clk_i = ~core_clk_i;
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// Toggle one input and count divided pulses, mux must follow
	task automatic pulses(input logic vco, input int edges, input int exp);
		int cnt;
		cnt = 0;
		for (int i = 0; i < edges * 4 + 8; i++) begin
			@(negedge core_clk_i);
			if (i < edges * 4) begin
				if (vco) vco_in_i = (i % 4) < 2;
				else ref_in_i = (i % 4) < 2;
			end
			cnt += vco ? int'(vpulse) : int'(rpulse);
			check(32'(mux_out), 32'(vco ? vpulse : rpulse));
		end
		check(cnt, exp);
	endtask
	task automatic t_reset();
		check(32'({cfg, mode, rdiv}), 32'h0);
		check(32'({main_c, swal}), 32'(ssp_pkg::COUNTER_RST[17:0]));
		check(32'(mux_out), 32'h0);
		$display("test reset done");
	endtask
	task automatic t_serial();
		logic [31:0] d;
		d = 32'hb47f0000;
		ssp_host_i.send(d, 32);
		for (int k = 24; k <= 32; k++) begin
			check(32'(ssp_host_i.seen[k]), 32'(d[55 - k]));
		end
		check(32'({main_c, swal, cfg}), 32'h0);
		$display("test serial done");
	endtask
	task automatic t_config();
		ssp_host_i.stray(5);
		ssp_host_i.send(32'h5a, 8);
		check(32'(cfg), 32'h5a);
		ssp_host_i.send(32'hfff, 12);
		check(32'(cfg), 32'h5a);
		$display("test config done");
	endtask
	task automatic t_ref();
		ssp_host_i.send(32'ha123, 16);
		check(32'(mode), 32'h5);
		check(32'(rdiv), 32'h0);
		ssp_host_i.send(32'h0, 0);
		check(32'(rdiv), 32'h0123);
		$display("test reference done");
	endtask
	task automatic t_counter();
		ssp_host_i.send(32'h0006, 16);
		check(32'(rdiv), 32'h0123);
		ssp_host_i.send(32'h0000c2, 24);
		check(32'(rdiv), 32'h6);
		check(32'({main_c, swal}), 32'h0c2);
		check(32'(mux_out), 32'h1);
		ssp_host_i.send(32'h58, 8);
		check(32'(mux_out), 32'h0);
		$display("test counter done");
	endtask
	task automatic t_divide();
		ssp_host_i.send(32'hc000c2, 24);
		pulses(1'b0, 60, 10);
		ssp_host_i.send(32'h800081, 24);
		pulses(1'b1, 258, 2);
		$display("test dividers done");
	endtask
	initial begin
		err_count = 0;
		checks_done = 0;
		rst_n_i = 1'b0;
		ref_in_i = 1'b0;
		vco_in_i = 1'b0;
		repeat (5) @(negedge core_clk_i);
		rst_n_i = 1'b1;
		repeat (5) @(negedge core_clk_i);
		t_reset();
		t_serial();
		t_config();
		t_ref();
		t_counter();
		t_divide();
		give_verdict();
	end
	// Hang guard
	initial begin
		#400000;
		err_count++;
		give_verdict();
	end
endmodule // tb
